// >>> src/urx_receiver.sv
// Purpose: Serial receive path with two-word buffer and error flags
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Status read then data read pops a word and clears flags
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module urx_receiver (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        rx_pin,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	output logic             rx_irq
);
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	logic [urx_pkg::CTRL_W-1:0]  ctrl;
	logic [15:0]                 divisor;
	urx_pkg::urx_state_e         state;
	logic [3:0]                  phase;
	logic [3:0]                  bitn;
	logic [1:0]                  smp;
	logic [urx_pkg::WORD_W-1:0]  shreg;
	logic                        noise_acc;
	logic                        par_acc;
	logic                        parity_error_flag_acc;
	logic [urx_pkg::ENTRY_W-1:0] fifo_mem [urx_pkg::DEPTH];
	logic                        wr_ptr;
	logic                        rd_ptr;
	logic [1:0]                  count;
	logic                        overrun;
	logic                        stat_seen;

	urx_rec_if rif ();

	urx_sampler u_smp (
		.clock  (clock),
		.srst   (srst),
		.rx_pin (rx_pin),
		.rif    (rif)
	);

	assign rif.divisor = divisor;
	assign rif.run     = ctrl[urx_pkg::C_EN];

	// Bus decode
	wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr       = req & wb_we_i;
	wire rd       = req & ~wb_we_i;
	wire hit_ctrl = wb_adr_i == urx_pkg::ADR_CTRL;
	wire hit_baud = wb_adr_i == urx_pkg::ADR_BAUD;
	wire hit_stat = wb_adr_i == urx_pkg::ADR_STAT;
	wire hit_data = wb_adr_i == urx_pkg::ADR_DATA;

	// Bit decision around the bit centre
	wire       tick      = rif.tick;
	wire       decide    = tick & (phase == urx_pkg::PH_S2);
	wire [2:0] votes     = {smp, rif.line};
	wire       bit_v     = maj3(votes);
	wire       bit_noisy = (|votes) & ~(&votes);
	wire [3:0] nbits     = ctrl[urx_pkg::C_WLS] ? urx_pkg::BITS_9
	                                            : urx_pkg::BITS_8;
	wire       two_stop  = ctrl[urx_pkg::C_STOP2];
	wire       in_stop1  = state == urx_pkg::ST_STOP1;
	wire       in_stop2  = state == urx_pkg::ST_STOP2;
	wire       stop_done = decide & ((in_stop1 & ~(bit_v & two_stop))
	                                 | in_stop2);
	wire       frm_framing_error_flag  = ~bit_v;
	wire       frm_noise = noise_acc | bit_noisy;

	// Buffer control
	wire avail  = count != 2'h0;
	wire pop    = rd & hit_data & stat_seen & avail;
	wire full   = (count == 2'h2) & ~pop;
	wire push   = stop_done & ~full;
	wire ovr_ev = stop_done & full;

	wire [urx_pkg::ENTRY_W-1:0] head = avail ? fifo_mem[rd_ptr]
	                                         : '0;
	wire idle = (state == urx_pkg::ST_HUNT)
	          | (state == urx_pkg::ST_BRK);

	wire [31:0] ctrl_rd = {23'h000000, head[urx_pkg::WORD_W-1],
	                       2'h0, ctrl};
	wire [31:0] stat_rd = {26'h0000000, avail, idle, overrun,
	                       head[urx_pkg::E_NOISE], head[urx_pkg::E_FRAMING_ERROR_FLAG],
	                       head[urx_pkg::E_PARITY_ERROR_FLAG]};
	wire [31:0] data_rd = {23'h000000, head[urx_pkg::WORD_W-1:0]};
	wire [31:0] baud_rd = {16'h0000, divisor};
	wire [31:0] rd_val  = hit_ctrl ? ctrl_rd :
	                      hit_baud ? baud_rd :
	                      hit_stat ? stat_rd :
	                      hit_data ? data_rd : 32'h00000000;

	// Software registers
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl    <= urx_pkg::CTRL_RST;
			divisor <= urx_pkg::BAUD_RST;
		end else if (wr) begin
			if (hit_ctrl && wb_sel_i[0]) begin
				ctrl <= wb_dat_i[urx_pkg::CTRL_W-1:0];
			end
			if (hit_baud && wb_sel_i[0]) begin
				divisor[7:0] <= wb_dat_i[7:0];
			end
			if (hit_baud && wb_sel_i[1]) begin
				divisor[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Bus answer, one cycle after the request is taken
	always_ff @(posedge clock) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (rd) begin
				wb_dat_o <= rd_val;
			end
		end
	end

	// Frame sequencer
	always_ff @(posedge clock) begin
		if (srst || !ctrl[urx_pkg::C_EN]) begin
			state <= urx_pkg::ST_HUNT;
			phase <= 4'h0;
		end else begin
			if (tick) begin
				phase <= (state == urx_pkg::ST_HUNT) ? 4'h0
				                                     : phase + 4'h1;
			end
			unique case (state)
				urx_pkg::ST_HUNT: begin
					if (tick && !rif.line) begin
						state <= urx_pkg::ST_START;
					end
				end
				urx_pkg::ST_START: begin
					if (tick && phase == urx_pkg::PH_S1 && rif.line) begin
						state <= urx_pkg::ST_HUNT;
					end else if (decide) begin
						state <= bit_v ? urx_pkg::ST_HUNT
						               : urx_pkg::ST_DATA;
					end
				end
				urx_pkg::ST_DATA: begin
					if (decide && bitn == nbits - 4'h1) begin
						state <= ctrl[urx_pkg::C_PEN] ? urx_pkg::ST_PAR
						                              : urx_pkg::ST_STOP1;
					end
				end
				urx_pkg::ST_PAR: begin
					if (decide) begin
						state <= urx_pkg::ST_STOP1;
					end
				end
				urx_pkg::ST_STOP1: begin
					if (decide) begin
						if (bit_v && two_stop) begin
							state <= urx_pkg::ST_STOP2;
						end else begin
							state <= bit_v ? urx_pkg::ST_HUNT
							               : urx_pkg::ST_BRK;
						end
					end
				end
				urx_pkg::ST_STOP2: begin
					if (decide) begin
						state <= bit_v ? urx_pkg::ST_HUNT
						               : urx_pkg::ST_BRK;
					end
				end
				urx_pkg::ST_BRK: begin
					if (tick && rif.line) begin
						state <= urx_pkg::ST_HUNT;
					end
				end
			endcase
		end
	end

	// Word assembly
	always_ff @(posedge clock) begin
		if (srst || state == urx_pkg::ST_HUNT) begin
			bitn      <= 4'h0;
			shreg     <= '0;
			smp       <= 2'h0;
			noise_acc <= 1'b0;
			par_acc   <= 1'b0;
			parity_error_flag_acc  <= 1'b0;
		end else begin
			if (tick && (phase == urx_pkg::PH_S0 ||
			             phase == urx_pkg::PH_S1)) begin
				smp <= {smp[0], rif.line};
			end
			if (decide) begin
				noise_acc <= noise_acc | bit_noisy;
				if (state == urx_pkg::ST_DATA) begin
					shreg[bitn] <= bit_v;
					bitn        <= bitn + 4'h1;
					par_acc     <= par_acc ^ bit_v;
				end
				if (state == urx_pkg::ST_PAR) begin
					parity_error_flag_acc <= par_acc ^ bit_v
					          ^ ctrl[urx_pkg::C_PODD];
				end
			end
		end
	end

	// Two-entry receive buffer, flags stored with each word
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < urx_pkg::DEPTH; i++) begin
				fifo_mem[i] <= '0;
			end
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push) begin
				fifo_mem[wr_ptr] <= {frm_noise, parity_error_flag_acc, frm_framing_error_flag,
				                     shreg};
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			unique case ({push, pop})
				2'b10:   count <= count + 2'h1;
				2'b01:   count <= count - 2'h1;
				default: count <= count;
			endcase
		end
	end

	// Flag clearing sequence and interrupt request
	always_ff @(posedge clock) begin
		if (srst) begin
			overrun   <= 1'b0;
			stat_seen <= 1'b0;
			rx_irq    <= 1'b0;
		end else begin
			if (ovr_ev) begin
				overrun <= 1'b1;
			end else if (pop) begin
				overrun <= 1'b0;
			end
			if (rd && hit_stat) begin
				stat_seen <= 1'b1;
			end else if (rd && hit_data) begin
				stat_seen <= 1'b0;
			end
			rx_irq <= ctrl[urx_pkg::C_RIE] & (push | ovr_ev);
		end
	end
endmodule
`default_nettype wire

// >>> src/urx_pkg.sv
// Purpose: Shared constants and types for the serial receiver
// Assumes: 32-bit classic Wishbone slave, byte addresses
// Notes:   Baud rate is clock / (16 * (divisor + 1))
package urx_pkg;
	// Register byte addresses
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_BAUD = 4'h4;
	localparam logic [3:0] ADR_STAT = 4'h8;
	localparam logic [3:0] ADR_DATA = 4'hc;

	// control_reg_one fields
	localparam int C_EN    = 0;
	localparam int C_WLS   = 1;
	localparam int C_PEN   = 2;
	localparam int C_PODD  = 3;
	localparam int C_RIE   = 4;
	localparam int C_STOP2 = 5;
	localparam int C_NINTH = 8;
	localparam int CTRL_W  = 6;

	// status_register_uart fields
	localparam int S_PARITY_ERROR_FLAG  = 0;
	localparam int S_FRAMING_ERROR_FLAG  = 1;
	localparam int S_NOISE = 2;
	localparam int S_OVR   = 3;
	localparam int S_IDLE  = 4;
	localparam int S_AVAIL = 5;

	// FIFO entry layout
	localparam int WORD_W  = 9;
	localparam int E_FRAMING_ERROR_FLAG  = 9;
	localparam int E_PARITY_ERROR_FLAG  = 10;
	localparam int E_NOISE = 11;
	localparam int ENTRY_W = 12;
	localparam int DEPTH   = 2;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [15:0]       BAUD_RST = 16'h0000;
	localparam logic              LINE_RST = 1'h1;

	// Oversampling: 16 ticks per bit, votes at ticks 7, 8, 9
	localparam int         OVERSAMPLE = 16;
	localparam logic [3:0] PH_S0      = 4'h7;
	localparam logic [3:0] PH_S1      = 4'h8;
	localparam logic [3:0] PH_S2      = 4'h9;
	localparam logic [3:0] BITS_8     = 4'h8;
	localparam logic [3:0] BITS_9     = 4'h9;

	typedef enum logic [2:0] {
		ST_HUNT,
		ST_START,
		ST_DATA,
		ST_PAR,
		ST_STOP1,
		ST_STOP2,
		ST_BRK
	} urx_state_e;
endpackage

// >>> src/urx_rec_if.sv
// Purpose: Link between the bit-clock recovery stage and the frame logic
// Assumes: Single clock domain
// Notes:   tick is a one-cycle enable at 16 times the baud rate
`timescale 1ns/1ns
`default_nettype none
interface urx_rec_if;
	logic        tick;
	logic        line;
	logic [15:0] divisor;
	logic        run;

	modport rec (output tick, output line, input divisor, input run);
	modport core (input tick, input line, output divisor, output run);
endinterface
`default_nettype wire

// >>> src/urx_sampler.sv
// Purpose: Pin synchroniser and 16x oversampling tick generator
// Assumes: rx_pin is asynchronous to clock
// Notes:   line follows the pin once two late stages agree
`timescale 1ns/1ns
`default_nettype none
module urx_sampler (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic rx_pin,
	urx_rec_if.rec    rif
);
	logic        sync1;
	logic        sync2;
	logic        sync3;
	logic [15:0] cnt;

	always_ff @(posedge clock) begin
		if (srst) begin
			sync1    <= urx_pkg::LINE_RST;
			sync2    <= urx_pkg::LINE_RST;
			sync3    <= urx_pkg::LINE_RST;
			rif.line <= urx_pkg::LINE_RST;
		end else begin
			sync1 <= rx_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				rif.line <= sync3;
			end
		end
	end

	// Divider producing the 16x enable
	always_ff @(posedge clock) begin
		if (srst || !rif.run) begin
			cnt      <= rif.divisor;
			rif.tick <= 1'b0;
		end else if (cnt == 16'h0000) begin
			cnt      <= rif.divisor;
			rif.tick <= 1'b1;
		end else begin
			cnt      <= cnt - 16'h0001;
			rif.tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/urx_receiver_asserts.sv
// Purpose: Port-level checks for the serial receiver
// Assumes: One clock, synchronous active-high reset
// Notes:   FRAME_MAX bounds one frame in clocks at the bench's rate
`timescale 1ns/1ns
`default_nettype none
module urx_receiver_chk #(parameter int FRAME_MAX = 512) (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        rx_pin,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        rx_irq
);
	logic       rx_interrupt_enable;
	logic [9:0] age;
	wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        ctrl_wr = req && wb_we_i && wb_adr_i == urx_pkg::ADR_CTRL;

	// Shadow of the interrupt enable, taken at the write's taking edge
	always_ff @(posedge clock) begin
		if (srst)
			rx_interrupt_enable <= 1'b0;
		else if (ctrl_wr && wb_sel_i[0])
			rx_interrupt_enable <= wb_dat_i[urx_pkg::C_RIE];
	end

	// Clocks since the line was last low; a stored word needs a frame
	always_ff @(posedge clock) begin
		if (srst || !rx_pin)
			age <= 10'h000;
		else if (age != 10'h3ff)
			age <= age + 10'h001;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence rd_at(logic [3:0] a);
		req && !wb_we_i && wb_adr_i == a;
	endsequence

	ack_answer_a: assert property (req |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
		else $error("ack without a request");
	irq_pulse_a: assert property (rx_irq |=> !rx_irq)
		else $error("interrupt longer than one cycle");
	irq_enable_a: assert property (rx_irq |-> rx_interrupt_enable)
		else $error("interrupt while disabled");
	irq_frame_a: assert property (rx_irq |-> age < FRAME_MAX)
		else $error("interrupt without a recent frame");
	unmapped_a: assert property (req && !wb_we_i && wb_adr_i[1:0] != 2'h0
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	data_width_a: assert property (rd_at(urx_pkg::ADR_DATA)
		|=> wb_dat_o[31:9] == 23'h0)
		else $error("data read wider than nine bits");
	noise_avail_a: assert property (rd_at(urx_pkg::ADR_STAT)
		|=> !wb_dat_o[urx_pkg::S_NOISE] || wb_dat_o[urx_pkg::S_AVAIL])
		else $error("noise flag without data");
	ovr_avail_a: assert property (rd_at(urx_pkg::ADR_STAT)
		|=> !wb_dat_o[urx_pkg::S_OVR] || wb_dat_o[urx_pkg::S_AVAIL])
		else $error("overrun flag without data");
endmodule

bind urx_receiver urx_receiver_chk chk (.clock(clock), .srst(srst),
	.rx_pin(rx_pin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.rx_irq(rx_irq));
`default_nettype wire

// >>> testbench/urx_line_model.sv
// Purpose: Remote serial transmitter driving the receive line
// Assumes: BIT clocks per bit, line idles high
// Notes:   Can corrupt parity, the last stop bit, send breaks or glitches
`timescale 1ns/1ns
`default_nettype none
module urx_line_model #(parameter int BIT = 32) (
	input  wire logic clock,
	output logic      rx_pin
);
	initial rx_pin = 1'b1;

	task automatic hold(input logic v, input int n);
		@(posedge clock);
		rx_pin <= v;
		repeat (n - 1) @(posedge clock);
	endtask

	task automatic send(input logic [8:0] w, input logic nine, input logic pen,
		input logic podd, input logic badp, input int stops,
		input logic badstop, input logic brk, input logic glitch);
		logic [8:0] d;
		logic       p;
		d = brk ? 9'h000 : (nine ? w : {1'b0, w[7:0]});
		p = (^d) ^ podd ^ badp;
		hold(1'b0, BIT);
		for (int i = 0; i < (nine ? 9 : 8); i++) begin
			if (glitch && i == 0) begin
				hold(d[0], 19);
				hold(!d[0], 2);
				hold(d[0], BIT - 21);
			end else
				hold(d[i], BIT);
		end
		if (pen)
			hold(brk ? 1'b0 : p, BIT);
		for (int i = 0; i < stops; i++)
			hold(!(brk || (badstop && i == stops - 1)), BIT);
		if (brk)
			hold(1'b0, 4 * BIT);
		hold(1'b1, BIT);
	endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the serial receiver
// Assumes: Divisor 1, so one bit is 32 clocks
// Notes:   Status values are {avail, idle, ovr, noise, framing_error_flag, parity_error_flag}
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	err_count++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module testbench;
	localparam int BIT = 32;
	logic        clock, srst, cyc, stb, we, ack, rx_irq;
	logic [3:0]  adr;
	logic [31:0] dat, rdat, q;
	logic [3:0]  sel, bsel;
	wire         rx_pin;
	int          err_count, comparisons, irqs;

	urx_line_model #(.BIT(BIT)) line (.clock(clock), .rx_pin(rx_pin));
	urx_receiver dut (.clock(clock), .srst(srst), .rx_pin(rx_pin),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.rx_irq(rx_irq));

	always @(posedge clock) if (rx_irq === 1'b1) irqs++;

	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		sel <= bsel;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		`CHK(n < 20, 1'b1)
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask

	task automatic st(input logic [5:0] e);
		xfer(urx_pkg::ADR_STAT, 1'b0, 32'h0);
		`CHK(q[5:0], e)
	endtask

	task automatic rdd(input logic [8:0] e);
		xfer(urx_pkg::ADR_DATA, 1'b0, 32'h0);
		`CHK(q[8:0], e)
	endtask

	task automatic t_regs();
		xfer(urx_pkg::ADR_CTRL, 1'b0, 32'h0);
		`CHK(q, 32'h0)
		xfer(4'h2, 1'b1, 32'hffffffff);
		xfer(4'h2, 1'b0, 32'h0);
		`CHK(q, 32'h0)
		xfer(urx_pkg::ADR_BAUD, 1'b1, 32'h1);
		xfer(urx_pkg::ADR_BAUD, 1'b0, 32'h0);
		`CHK(q[15:0], 16'h0001)
		bsel = 4'h2;
		xfer(urx_pkg::ADR_BAUD, 1'b1, 32'h0000ff00);
		bsel = 4'hf;
		xfer(urx_pkg::ADR_BAUD, 1'b0, 32'h0);
		`CHK(q[15:0], 16'hff01)
		xfer(urx_pkg::ADR_BAUD, 1'b1, 32'h1);
		line.send(9'h05a, 0, 0, 0, 0, 1, 0, 0, 0);
		xfer(urx_pkg::ADR_CTRL, 1'b1, 32'h01);
		st(6'h10);
		// Data read with nothing held ends the status-then-data pairing
		rdd(9'h000);
	endtask

	task automatic t_fifo();
		xfer(urx_pkg::ADR_CTRL, 1'b1, 32'h11);
		line.send(9'h0a5, 0, 0, 0, 0, 1, 0, 0, 0);
		rdd(9'h0a5);
		line.send(9'h03c, 0, 0, 0, 0, 1, 0, 0, 0);
		line.send(9'h05a, 0, 0, 0, 0, 1, 0, 0, 0);
		`CHK(irqs, 3)
		rdd(9'h0a5);
		st(6'h38);
		rdd(9'h0a5);
		st(6'h30);
		rdd(9'h03c);
		st(6'h10);
		rdd(9'h000);
	endtask

	task automatic t_parity();
		for (int m = 0; m < 4; m++) begin
			xfer(urx_pkg::ADR_CTRL, 1'b1, 32'h07 | (m[0] << 3));
			line.send(9'h1a5 ^ m, 1, 1, m[0], m[1], 1, 0, 0, 0);
			xfer(urx_pkg::ADR_CTRL, 1'b0, 32'h0);
			`CHK(q[8], 1'b1)
			st(6'h30 | m[1]);
			rdd(9'h1a5 ^ m);
		end
		`CHK(irqs, 3)
	endtask

	task automatic t_errors();
		xfer(urx_pkg::ADR_CTRL, 1'b1, 32'h11);
		fork
			line.send(9'h0, 0, 0, 0, 0, 1, 0, 1, 0);
			begin
				repeat (12 * BIT) @(posedge clock);
				st(6'h32);
				rdd(9'h000);
			end
		join
		`CHK(irqs, 4)
		line.send(9'h055, 0, 0, 0, 0, 1, 0, 0, 0);
		st(6'h30);
		rdd(9'h055);
		fork
			line.send(9'h0ff, 0, 0, 0, 0, 1, 0, 0, 0);
			begin
				repeat (5 * BIT) @(posedge clock);
				st(6'h00);
			end
		join
		st(6'h30);
		rdd(9'h0ff);
		xfer(urx_pkg::ADR_CTRL, 1'b1, 32'h21);
		line.send(9'h081, 0, 0, 0, 0, 2, 1, 0, 0);
		st(6'h32);
		rdd(9'h081);
		line.send(9'h096, 0, 0, 0, 0, 1, 0, 0, 1);
		st(6'h34);
		rdd(9'h096);
		st(6'h10);
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		give_verdict();
	end

	initial begin
		srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0;
		dat = 32'h0; err_count = 0; comparisons = 0; irqs = 0;
		sel = 4'hf;
		bsel = 4'hf;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		t_regs();
		t_fifo();
		t_parity();
		t_errors();
		give_verdict();
	end
endmodule
`default_nettype wire
